/* common/tmwv_pkg.sv */
// constants for the 16-bit timer waveform generator
// assumes an AHB-Lite slave slot with 8 low address bits decoded
package tmwv_pkg;
   localparam logic [7:0]  ADDR_CTRL  = 8'h00;
   localparam logic [7:0]  ADDR_COUNT = 8'h04;
   localparam logic [7:0]  ADDR_CMPA  = 8'h08;
   localparam logic [7:0]  ADDR_CMPB  = 8'h0C;
   localparam logic [7:0]  ADDR_CAPT  = 8'h10;
   localparam logic [7:0]  ADDR_FLAGS = 8'h14;
   localparam int          CTRL_CS    = 4;
   localparam int          CTRL_COMA  = 8;
   localparam int          CTRL_COMB  = 10;
   localparam int          CTRL_DIRA  = 12;
   localparam int          CTRL_DIRB  = 13;
   localparam logic [13:0] CTRL_RST   = 14'h0000;
   localparam logic [15:0] CNT_RST    = 16'h0000;
   localparam logic [15:0] TOP_8      = 16'h00FF;
   localparam logic [15:0] TOP_9      = 16'h01FF;
   localparam logic [15:0] TOP_10     = 16'h03FF;
   localparam logic [15:0] TOP_MAX    = 16'hFFFF;
   localparam int          FLG_OVF    = 0;
   localparam int          FLG_CMPA   = 1;
   localparam int          FLG_CMPB   = 2;
   localparam int          FLG_CAPT   = 3;
   localparam logic [9:0]  DIV_8_M1   = 10'h007;
   localparam logic [9:0]  DIV_64_M1  = 10'h03F;
   localparam logic [9:0]  DIV_256_M1 = 10'h0FF;
   localparam logic [9:0]  DIV_1K_M1  = 10'h3FF;
   typedef enum logic [2:0] {
      MODE_NORMAL = 3'b000,
      MODE_CTC    = 3'b001,
      MODE_FAST   = 3'b010,
      MODE_PC     = 3'b011,
      MODE_PFC    = 3'b100
   } tmwv_mode_e;
endpackage : tmwv_pkg

/* logic/tmwv_top.sv */
// 16-bit timer waveform generator with AHB-Lite register slave
// assumes a single clock domain and one AHB-Lite master
`timescale 1ns/1ps
`default_nettype none
module tmwv_top
   import tmwv_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic        hreadyout,
   output var  logic        hresp,
   output var  logic [31:0] hrdata,
   output wire logic        pin_a_out,
   output wire logic        pin_a_oe,
   output wire logic        pin_b_out,
   output wire logic        pin_b_oe
);

   logic        ap_wr;
   logic [7:0]  ap_addr;
   logic        acc;
   logic [13:0] ctrl;
   logic [15:0] cnt;
   logic [15:0] capture_value;
   logic [3:0]  flags;
   logic [3:0]  clr;
   logic        up;
   logic [9:0]  pre;
   logic [9:0]  div_m1;
   logic        run;
   logic        tick;
   logic [3:0]  wgm;
   logic [2:0]  cs;
   tmwv_mode_e  mode;
   logic [15:0] top;
   logic        top_cap;
   logic        top_a;
   logic        dual;
   logic        buffered;
   logic        at_top;
   logic        at_bot;
   logic        ld;
   logic        wr_ctrl;
   logic        wr_cnt;
   logic        wr_capt;
   logic        wr_flag;
   logic [1:0]  wr_cmp;
   logic [15:0] act [2];
   logic [15:0] cbuf [2];
   logic [1:0]  com [2];
   logic [1:0]  dir;
   logic [1:0]  oc;
   logic [1:0]  m;
   logic [1:0]  seen;
   logic [1:0]  po;
   logic [1:0]  poe;

   assign wgm = ctrl[3:0];
   assign cs = ctrl[CTRL_CS +: 3];
   assign com[0] = ctrl[CTRL_COMA +: 2];
   assign com[1] = ctrl[CTRL_COMB +: 2];
   assign dir = {ctrl[CTRL_DIRB], ctrl[CTRL_DIRA]};
   assign pin_a_out = po[0];
   assign pin_b_out = po[1];
   assign pin_a_oe = poe[0];
   assign pin_b_oe = poe[1];

   // bus slave: zero wait states, every transfer OKAY
   assign acc = hsel & htrans[1] & hready;
   assign wr_ctrl = ap_wr & (ap_addr == ADDR_CTRL);
   assign wr_cnt = ap_wr & (ap_addr == ADDR_COUNT);
   assign wr_cmp[0] = ap_wr & (ap_addr == ADDR_CMPA);
   assign wr_cmp[1] = ap_wr & (ap_addr == ADDR_CMPB);
   assign wr_capt = ap_wr & (ap_addr == ADDR_CAPT);
   assign wr_flag = ap_wr & (ap_addr == ADDR_FLAGS);
   assign clr = wr_flag ? hwdata[3:0] : 4'h0;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ap_wr <= 1'b0;
         ap_addr <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         ap_wr <= acc & hwrite;
         ap_addr <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // read data is latched at the address phase edge
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hrdata <= 32'h00000000;
      end else if (acc & ~hwrite) begin
         case (haddr[7:0])
            ADDR_CTRL:  hrdata <= {18'h00000, ctrl};
            ADDR_COUNT: hrdata <= {16'h0000, cnt};
            ADDR_CMPA:  hrdata <= {16'h0000, cbuf[0]};
            ADDR_CMPB:  hrdata <= {16'h0000, cbuf[1]};
            ADDR_CAPT:  hrdata <= {16'h0000, capture_value};
            ADDR_FLAGS: hrdata <= {28'h0000000, flags};
            default:    hrdata <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl <= CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl <= hwdata[13:0];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         capture_value <= CNT_RST;
      end else if (wr_capt) begin
         capture_value <= hwdata[15:0];
      end
   end

   // prescaler
   always_comb begin
      run = 1'b1;
      div_m1 = 10'h000;
      case (cs)
         3'd1: div_m1 = 10'h000;
         3'd2: div_m1 = DIV_8_M1;
         3'd3: div_m1 = DIV_64_M1;
         3'd4: div_m1 = DIV_256_M1;
         3'd5: div_m1 = DIV_1K_M1;
         default: run = 1'b0;
      endcase
   end

   assign tick = run & (pre == div_m1);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pre <= 10'h000;
      end else if (tick | ~run) begin
         pre <= 10'h000;
      end else begin
         pre <= pre + 10'h001;
      end
   end

   // mode and TOP decode
   always_comb begin
      mode = MODE_NORMAL;
      top = TOP_MAX;
      top_cap = 1'b0;
      case (wgm)
         4'd4: begin
            mode = MODE_CTC;
            top = act[0];
         end
         4'd12: begin
            mode = MODE_CTC;
            top = capture_value;
            top_cap = 1'b1;
         end
         4'd5: begin
            mode = MODE_FAST;
            top = TOP_8;
         end
         4'd6: begin
            mode = MODE_FAST;
            top = TOP_9;
         end
         4'd7: begin
            mode = MODE_FAST;
            top = TOP_10;
         end
         4'd14: begin
            mode = MODE_FAST;
            top = capture_value;
            top_cap = 1'b1;
         end
         4'd15: begin
            mode = MODE_FAST;
            top = act[0];
         end
         4'd1: begin
            mode = MODE_PC;
            top = TOP_8;
         end
         4'd2: begin
            mode = MODE_PC;
            top = TOP_9;
         end
         4'd3: begin
            mode = MODE_PC;
            top = TOP_10;
         end
         4'd10: begin
            mode = MODE_PC;
            top = capture_value;
            top_cap = 1'b1;
         end
         4'd11: begin
            mode = MODE_PC;
            top = act[0];
         end
         4'd8: begin
            mode = MODE_PFC;
            top = capture_value;
            top_cap = 1'b1;
         end
         4'd9: begin
            mode = MODE_PFC;
            top = act[0];
         end
         default: begin
            mode = MODE_NORMAL;
            top = TOP_MAX;
         end
      endcase
   end

   assign top_a = (wgm == 4'd4) | (wgm == 4'd15) | (wgm == 4'd11) | (wgm == 4'd9);
   assign dual = (mode == MODE_PC) | (mode == MODE_PFC);
   assign buffered = (mode != MODE_NORMAL) & (mode != MODE_CTC);
   assign at_top = (cnt == top);
   assign at_bot = (cnt == 16'h0000);
   assign ld = tick & (((mode == MODE_FAST) & at_top)
             | ((mode == MODE_PC) & at_top & up)
             | ((mode == MODE_PFC) & at_bot & ~up));

   // counter; a compare A written below the count is simply passed by
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt <= CNT_RST;
         up <= 1'b1;
      end else if (wr_cnt) begin
         cnt <= hwdata[15:0];
      end else if (tick) begin
         if (!dual) begin
            up <= 1'b1;
            cnt <= at_top ? 16'h0000 : cnt + 16'h0001;
         end else if (up) begin
            if (cnt >= top) begin
               up <= 1'b0;
               cnt <= cnt - 16'h0001;
            end else begin
               cnt <= cnt + 16'h0001;
            end
         end else if (at_bot) begin
            up <= 1'b1;
            cnt <= cnt + 16'h0001;
         end else begin
            cnt <= cnt - 16'h0001;
         end
      end
   end

   // sticky flags, write one to clear; a set in the same cycle wins
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flags <= 4'h0;
      end else begin
         flags[FLG_OVF] <= (flags[FLG_OVF] & ~clr[FLG_OVF])
            | (tick & (dual ? (at_bot & ~up) : at_top));
         flags[FLG_CMPA] <= (flags[FLG_CMPA] & ~clr[FLG_CMPA]) | m[0];
         flags[FLG_CMPB] <= (flags[FLG_CMPB] & ~clr[FLG_CMPB]) | m[1];
         flags[FLG_CAPT] <= (flags[FLG_CAPT] & ~clr[FLG_CAPT])
            | (tick & at_top & top_cap);
      end
   end

   for (genvar i = 0; i < 2; i++) begin : g_ch
      assign m[i] = tick & (cnt == act[i]);

      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            cbuf[i] <= CNT_RST;
            act[i] <= CNT_RST;
         end else begin
            if (wr_cmp[i]) begin
               cbuf[i] <= hwdata[15:0];
            end
            if (wr_cmp[i] & ~buffered) begin
               act[i] <= hwdata[15:0];
            end else if (ld) begin
               act[i] <= cbuf[i];
            end
         end
      end

      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            seen[i] <= 1'b0;
         end else if (tick & at_bot) begin
            seen[i] <= 1'b0;
         end else if (m[i] & up) begin
            seen[i] <= 1'b1;
         end
      end

      // fast mode: the bottom restore beats a match at TOP, which
      // makes a compare of TOP a steady level
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            oc[i] <= 1'b0;
         end else begin
            case (mode)
               MODE_NORMAL, MODE_CTC: begin
                  if (m[i] & (com[i] == 2'd1)) begin
                     oc[i] <= ~oc[i];
                  end else if (m[i] & com[i][1]) begin
                     oc[i] <= com[i][0];
                  end
               end
               MODE_FAST: begin
                  if (m[i] & (com[i] == 2'd1) & (i == 0) & top_a) begin
                     oc[i] <= ~oc[i];
                  end else if (tick & at_top & com[i][1]) begin
                     oc[i] <= ~com[i][0];
                  end else if (m[i] & com[i][1]) begin
                     oc[i] <= com[i][0];
                  end
               end
               MODE_PC, MODE_PFC: begin
                  if (m[i] & (com[i] == 2'd1) & (i == 0) & top_a) begin
                     oc[i] <= ~oc[i];
                  end else if (tick & at_top & up & com[i][1]
                     & ((mode == MODE_PC) & (act[i] == top) & (cbuf[i] != top)
                     | ~seen[i] & (act[i] != 16'h0000) & (act[i] < top))) begin
                     oc[i] <= ~oc[i];
                  end else if (m[i] & com[i][1]) begin
                     oc[i] <= up ? com[i][0] : ~com[i][0];
                  end
               end
               default: oc[i] <= oc[i];
            endcase
         end
      end

      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            po[i] <= 1'b0;
            poe[i] <= 1'b0;
         end else begin
            po[i] <= oc[i] & dir[i];
            poe[i] <= dir[i];
         end
      end
   end

   ctc_wrap_a: assert property (@(posedge clock) disable iff (rst)
      (tick && mode == MODE_CTC && at_top && !wr_cnt) |=> (cnt == 16'h0000))
      else $error("clear-on-compare count did not return to zero");

   cmpa_flag_a: assert property (@(posedge clock) disable iff (rst)
      (tick && mode == MODE_CTC && !top_cap && at_top) |=> flags[FLG_CMPA])
      else $error("compare A flag not set at TOP");

   ctc_direct_a: assert property (@(posedge clock) disable iff (rst)
      (wr_cmp[0] && mode == MODE_CTC) |=> (act[0] == $past(hwdata[15:0])))
      else $error("compare A not applied at once");

   fast_load_a: assert property (@(posedge clock) disable iff (rst)
      (ld && mode == MODE_FAST && !wr_cmp[1]) |=> (act[1] == $past(cbuf[1])))
      else $error("buffered compare B not loaded at TOP");

   pc_turn_a: assert property (@(posedge clock) disable iff (rst)
      (tick && dual && up && at_top && !wr_cnt && !wr_ctrl) |=> (!up && cnt == $past(cnt) - 16'h0001))
      else $error("dual slope did not turn at TOP");

   pfc_ovf_a: assert property (@(posedge clock) disable iff (rst)
      (tick && mode == MODE_PFC && at_bot && !up) |=> flags[FLG_OVF])
      else $error("overflow flag missing at bottom");

   tick_rate_a: assert property (@(posedge clock) disable iff (rst)
      (tick && cs == 3'd2 && !wr_ctrl) |=> (!tick)[*7])
      else $error("divide by eight ticks too early");

   pin_gate_a: assert property (@(posedge clock) disable iff (rst)
      !dir[0] |=> !pin_a_out)
      else $error("pin A driven while direction is input");

   toggle_a: assert property (@(posedge clock) disable iff (rst)
      (m[0] && mode == MODE_CTC && com[0] == 2'd1) |=> (oc[0] != $past(oc[0])))
      else $error("output mode 1 did not toggle on match");

endmodule : tmwv_top
`default_nettype wire

/* test/tmwv_load.sv */
// load model on one compare output pin: measures period, high time and rising edges
// assumes a pull-down on the pin while its driver is released
`timescale 1ns/1ps
`default_nettype none
module tmwv_load (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        pin_out,
   input  wire logic        pin_oe,
   input  wire logic        clr,
   output var  logic [31:0] period,
   output var  logic [31:0] high_time,
   output var  logic [31:0] edges
);
   logic        level;
   logic        last;
   logic [31:0] run;
   logic [31:0] hrun;
   // a released pin is pulled low, so a gated output reads as a steady low
   assign level = pin_oe ? pin_out : 1'b0;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         last      <= 1'b0;
         run       <= 32'h0;
         hrun      <= 32'h0;
         period    <= 32'h0;
         high_time <= 32'h0;
         edges     <= 32'h0;
      end else begin
         last <= level;
         run  <= run + 32'h1;
         hrun <= hrun + 32'h1;
         if (level && !last) begin
            period <= run;
            run    <= 32'h1;
            hrun   <= 32'h1;
         end
         if (!level && last) begin
            high_time <= hrun;
         end
         edges <= clr ? 32'h0 : edges + {31'h0, level && !last};
      end
   end
endmodule : tmwv_load
`default_nettype wire

/* test/tb_timer16_waveform_modes.sv */
// bench for the timer waveform generator: registers over AHB-Lite, pins watched by load models
// assumes hready is the slave's own hreadyout and one count tick per clock at prescale 1
`timescale 1ns/1ps
`default_nettype none
module tb_timer16_waveform_modes;
   import tmwv_pkg::*;
   logic        clock;
   logic        rst;
   logic        hsel;
   logic        hwrite;
   logic        load_clr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic        hreadyout;
   logic        hresp;
   logic        pin_a_out;
   logic        pin_a_oe;
   logic        pin_b_out;
   logic        pin_b_oe;
   logic [31:0] per_a;
   logic [31:0] per_b;
   logic [31:0] high_a;
   logic [31:0] edges_a;
   int          fails = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          div [5] = '{1, 8, 64, 256, 1024};

   tmwv_top u_tmwv_top (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe));
   tmwv_load load_a (.clock(clock), .rst(rst), .pin_out(pin_a_out), .pin_oe(pin_a_oe), .clr(load_clr),
      .period(per_a), .high_time(high_a), .edges(edges_a));
   tmwv_load load_b (.clock(clock), .rst(rst), .pin_out(pin_b_out), .pin_oe(pin_b_oe), .clr(load_clr),
      .period(per_b), .high_time(), .edges());

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task give_verdict();
      if (fails == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : give_verdict

   // the run is about 34k cycles, so this ceiling only trips on a hang
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         fails = fails + 1;
         give_verdict();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task wait_rdy();
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
   endtask : wait_rdy

   task bus_req(input logic [7:0] a, input logic w);
      @(posedge clock);
      hsel   <= 1'b1;
      haddr  <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
   endtask : bus_req

   task bus_write(input logic [7:0] a, input logic [31:0] d);
      bus_req(a, 1'b1);
      hwdata <= d;
      wait_rdy();
   endtask : bus_write

   task bus_read(input logic [7:0] a);
      bus_req(a, 1'b0);
      wait_rdy();
      rd = hrdata;
   endtask : bus_read

   function automatic logic [31:0] ctrl(input logic [3:0] wgm, input logic [2:0] cs, input logic [1:0] ma,
                                        input logic [1:0] mb, input logic da, input logic db);
      logic [31:0] v;
      v                = 32'h0;
      v[3:0]           = wgm;
      v[CTRL_CS+:3]    = cs;
      v[CTRL_COMA+:2]  = ma;
      v[CTRL_COMB+:2]  = mb;
      v[CTRL_DIRA]     = da;
      v[CTRL_DIRB]     = db;
      return v;
   endfunction : ctrl

   // stopping and zeroing first keeps a leftover count above the new TOP from a 64k wrap
   task setup(input logic [31:0] c, input logic [15:0] ca, input logic [15:0] cb, input logic [15:0] cp);
      bus_write(ADDR_CTRL, 32'h0);
      bus_write(ADDR_COUNT, 32'h0);
      bus_write(ADDR_CMPA, {16'h0000, ca});
      bus_write(ADDR_CMPB, {16'h0000, cb});
      bus_write(ADDR_CAPT, {16'h0000, cp});
      bus_write(ADDR_FLAGS, 32'h0000000F);
      bus_write(ADDR_CTRL, c);
   endtask : setup

   task wait_n(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : wait_n

   task quiet(input int n);
      wait_n(n);
      @(posedge clock) load_clr <= 1'b1;
      @(posedge clock) load_clr <= 1'b0;
      wait_n(n);
   endtask : quiet

   initial begin
      rst      = 1'b1;
      hsel     = 1'b0;
      haddr    = 32'h0;
      htrans   = 2'h0;
      hwrite   = 1'b0;
      hsize    = 3'h2;
      hwdata   = 32'h0;
      load_clr = 1'b0;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      bus_read(ADDR_CTRL);
      chk(rd, 32'h0);
      bus_read(ADDR_COUNT);
      chk(rd, 32'h0);
      bus_write(8'h18, 32'hFFFFFFFF);
      bus_read(8'h18);
      chk(rd, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      setup(ctrl(4'h4, 3'h1, 2'h1, 2'h0, 1'b1, 1'b0), 16'h0000, 16'h0000, 16'h0000);
      wait_n(20);
      chk(per_a, 32'h2);
      chk(high_a, 32'h1);
      for (int k = 0; k < 5; k++) begin
         setup(ctrl(4'h4, 3'(k + 1), 2'h1, 2'h0, 1'b1, 1'b0), 16'h0000, 16'h0000, 16'h0000);
         wait_n(6 * div[k] + 10);
         chk(per_a, 32'(2 * div[k]));
      end
      setup(ctrl(4'h4, 3'h1, 2'h1, 2'h0, 1'b1, 1'b0), 16'h0009, 16'h0000, 16'h0000);
      wait_n(60);
      chk(per_a, 32'h14);
      bus_read(ADDR_FLAGS);
      chk(rd & 32'hF, 32'h7);
      repeat (4) begin
         bus_read(ADDR_COUNT);
         chk({31'h0, rd < 32'hA}, 32'h1);
      end
      // a running compare A write above the count takes effect at once
      bus_write(ADDR_CMPA, 32'h00000013);
      wait_n(120);
      chk(per_a, 32'h28);
      setup(ctrl(4'hC, 3'h1, 2'h1, 2'h0, 1'b1, 1'b0), 16'h0005, 16'h0000, 16'h0013);
      wait_n(100);
      chk(per_a, 32'h28);
      bus_read(ADDR_FLAGS);
      chk(rd & 32'h9, 32'h9);
      for (int k = 0; k < 3; k++) begin
         setup(ctrl(4'(5 + k), 3'h1, 2'h2, 2'h2, 1'b1, 1'b1), 16'h0010, 16'h0020, 16'h0000);
         wait_n(3 * (256 << k) + 20);
         chk(per_a, 32'(256 << k));
         chk(per_b, 32'(256 << k));
      end
      setup(ctrl(4'hE, 3'h1, 2'h2, 2'h0, 1'b1, 1'b0), 16'h0010, 16'h0000, 16'h0063);
      wait_n(320);
      chk(per_a, 32'h64);
      setup(ctrl(4'hF, 3'h1, 2'h1, 2'h0, 1'b1, 1'b0), 16'h0031, 16'h0000, 16'h0000);
      wait_n(320);
      chk(per_a, 32'h64);
      chk(high_a, 32'h32);
      setup(ctrl(4'h5, 3'h1, 2'h2, 2'h0, 1'b1, 1'b0), 16'h0000, 16'h0000, 16'h0000);
      wait_n(800);
      chk(per_a, 32'h100);
      setup(ctrl(4'h5, 3'h1, 2'h2, 2'h0, 1'b1, 1'b0), 16'h00FF, 16'h0000, 16'h0000);
      quiet(600);
      chk(edges_a, 32'h0);
      for (int k = 0; k < 3; k++) begin
         setup(ctrl(4'(1 + k), 3'h1, 2'h2, 2'h2, 1'b1, 1'b1), 16'h0080, 16'h0040, 16'h0000);
         wait_n(6 * ((256 << k) - 1) + 20);
         chk(per_a, 32'(2 * ((256 << k) - 1)));
         chk(per_b, 32'(2 * ((256 << k) - 1)));
      end
      setup(ctrl(4'hA, 3'h1, 2'h2, 2'h0, 1'b1, 1'b0), 16'h0014, 16'h0000, 16'h0032);
      wait_n(340);
      chk(per_a, 32'h64);
      setup(ctrl(4'hB, 3'h1, 2'h0, 2'h2, 1'b0, 1'b1), 16'h0032, 16'h000A, 16'h0000);
      wait_n(340);
      chk(per_b, 32'h64);
      for (int k = 0; k < 2; k++) begin
         setup(ctrl(4'h1, 3'h1, 2'h2, 2'h0, 1'b1, 1'b0), k ? 16'h0000 : 16'h00FF, 16'h0000, 16'h0000);
         quiet(1100);
         chk(edges_a, 32'h0);
      end
      setup(ctrl(4'h8, 3'h1, 2'h2, 2'h0, 1'b1, 1'b0), 16'h000A, 16'h0000, 16'h0028);
      wait_n(280);
      chk(per_a, 32'h50);
      setup(ctrl(4'h9, 3'h1, 2'h0, 2'h2, 1'b0, 1'b1), 16'h0028, 16'h000A, 16'h0000);
      wait_n(280);
      chk(per_b, 32'h50);
      setup(ctrl(4'h4, 3'h1, 2'h1, 2'h0, 1'b0, 1'b0), 16'h0000, 16'h0000, 16'h0000);
      quiet(20);
      chk(edges_a, 32'h0);
      chk({30'h0, pin_a_oe, pin_a_out}, 32'h0);
      give_verdict();
   end
endmodule : tb_timer16_waveform_modes
`default_nettype wire
